// >>> hw/drive_ctrl_pkg.sv
// Register map, field layouts, codes and timing of the drive mode controller.
// Assumes a 20 MHz system clock and an AXI4-Lite register bus with 32-bit data.
package drive_ctrl_pkg;
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_MODE    = 8'h04;
  localparam logic [7:0]  OFF_TRQ     = 8'h08;
  localparam logic [7:0]  OFF_POS     = 8'h0c;
  localparam logic [7:0]  OFF_CFG     = 8'h10;
  localparam logic [7:0]  OFF_STAT    = 8'h14;
  localparam logic [7:0]  OFF_AMODE   = 8'h18;
  localparam logic [7:0]  OFF_ATORQ   = 8'h1c;
  localparam logic [7:0]  OFF_APOSL   = 8'h20;
  localparam logic [7:0]  OFF_APOSH   = 8'h24;
  localparam logic [15:0] MODE_SPEED  = 16'h0000;
  localparam logic [15:0] MODE_POS    = 16'h0001;
  localparam logic [15:0] MODE_TRQ    = 16'h0002;
  localparam logic [15:0] MODE_HOME   = 16'h0003;
  localparam logic [7:0]  MI_REV_LIM  = 8'h2c;
  localparam logic [7:0]  MI_FWD_LIM  = 8'h2d;
  localparam logic [7:0]  MI_ORIGIN   = 8'h2e;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          MOVE_MIN_NS   = 1000000;
  localparam int          MOVE_MIN_CYC  = (MOVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          MI_PINS       = 3;
  localparam int          MI_W          = 8;

  typedef struct packed {
    logic lock;
    logic halt;
    logic qstop;
    logic home;
    logic absrel;
    logic move;
    logic servo;
  } ctrl_t;

  typedef struct packed {
    logic [7:0] mi2;
    logic [7:0] mi1;
    logic [7:0] mi0;
    logic [1:0] sby_opt;
    logic       abs_cfg;
    logic       no_z;
    logic       foc;
  } cfg_t;

  typedef struct packed {
    logic hbusy;
    logic zhold;
    logic sby;
    logic hfault;
    logic hdone;
    logic tgt;
    logic treach;
    logic ready;
  } stat_t;

  typedef enum logic [2:0] {H_IDLE, H_SEARCH, H_ZWAIT, H_DONE, H_FAULT} home_st_t;

  localparam ctrl_t       CTRL_RST = '0;
  localparam cfg_t        CFG_RST  = '{mi2: MI_ORIGIN, mi1: MI_FWD_LIM, mi0: MI_REV_LIM, default: '0};
  localparam logic [15:0] MODE_RST = MODE_SPEED;
endpackage : drive_ctrl_pkg

// >>> hw/drive_mode_ctrl.sv
// Mode controller of a motor drive: torque, homing and point-to-point position.
// Assumes encoder position and motor torque arrive on CLK_IN; sensor pins are asynchronous.
// Behaviour
// - Actual mode word reports running mode, speed 0.
// - Torque command carries target torque and limit.
// - Servo on in torque mode applies target.
// - Report actual torque and torque-attained flag.
// - Move trigger works only in position mode, servo.
// - Reference bit: 0 relative, 1 absolute target.
// - Home start works only in homing mode, servo.
// - Set homing done, flag homing fault.
// - Homing to position keeps servo on.
// - Actual position split into low, high words.
// - Input codes 44, 45, 46 map sensors.
// - Only Z index ends homing; none faults.
// - Scalar control homing servo on gives standby.
// - Field-oriented homing servo on holds zero speed.
// - Absolute select by bit or configuration.
// - Priority: servo, quick stop, halt, lock.
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module drive_mode_ctrl #(
  parameter int MOVE_MIN = drive_ctrl_pkg::MOVE_MIN_CYC
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic [7:0]  AWADDR_IN,
  input  wire logic        AWVALID_IN,
  output logic             AWREADY_OUT,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic [3:0]  WSTRB_IN,
  input  wire logic        WVALID_IN,
  output logic             WREADY_OUT,
  output logic [1:0]       BRESP_OUT,
  output logic             BVALID_OUT,
  input  wire logic        BREADY_IN,
  input  wire logic [7:0]  ARADDR_IN,
  input  wire logic        ARVALID_IN,
  output logic             ARREADY_OUT,
  output logic [31:0]      RDATA_OUT,
  output logic [1:0]       RRESP_OUT,
  output logic             RVALID_OUT,
  input  wire logic        RREADY_IN,
  input  wire logic [15:0] MOTOR_TORQUE_IN,
  input  wire logic [31:0] ENC_POS_IN,
  input  wire logic [2:0]  MI_PIN_IN,
  input  wire logic        ZPHASE_IN,
  output logic             EXCITE_OUT,
  output logic             QSTOP_OUT,
  output logic             HALT_OUT,
  output logic             FLOCK_OUT,
  output logic             TRQ_EN_OUT,
  output logic [15:0]      TRQ_CMD_OUT,
  output logic [15:0]      SPD_LIM_OUT,
  output logic [31:0]      POS_CMD_OUT,
  output logic             MOVE_GO_OUT,
  output logic             HOME_RUN_OUT,
  output logic             ZERO_HOLD_OUT,
  output logic             STANDBY_OUT,
  output logic [1:0]       SBY_OPT_OUT
);
  localparam int MW = $clog2(MOVE_MIN + 1);

  drive_ctrl_pkg::ctrl_t     ctrl_q;
  drive_ctrl_pkg::cfg_t      cfg_q;
  drive_ctrl_pkg::stat_t     stat;
  drive_ctrl_pkg::home_st_t  home_st_q;
  logic [15:0]               mode_q;
  logic [31:0]               trq_q;
  logic [31:0]               pos_q;
  logic [15:0]               act_mode_q;
  logic [15:0]               atorq_q;
  logic [31:0]               apos_q;
  logic [15:0]               apos_hi_q;
  logic                      aw_hold_q;
  logic                      w_hold_q;
  logic [7:0]                awaddr_q;
  logic [31:0]               wdata_q;
  logic [3:0]                wstrb_q;
  logic                      do_wr;
  logic                      wr_map;
  logic [31:0]               wr_old;
  logic [31:0]               wr_val;
  logic                      rd_take;
  logic                      rd_map;
  logic [31:0]               rd_word;
  logic [MW-1:0]             hold_q;
  logic                      move_ok;
  logic                      accept;
  logic                      moving_q;
  logic                      tgt_q;
  logic                      treach_q;
  logic                      home_prev_q;
  logic                      home_go;
  logic                      z_prev_q;
  logic                      z_edge;
  logic [drive_ctrl_pkg::MI_PINS:0] flt;
  logic [drive_ctrl_pkg::MI_PINS-1:0] hit_rev;
  logic [drive_ctrl_pkg::MI_PINS-1:0] hit_fwd;
  logic [drive_ctrl_pkg::MI_PINS-1:0] hit_org;
  logic [drive_ctrl_pkg::MI_PINS*drive_ctrl_pkg::MI_W-1:0] mi_vec;
  logic                      rev_lim;
  logic                      fwd_lim;
  logic                      org_hit;

  // Byte-lane merge of a write into the present register word.
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Register view at an address; the flag tells whether the address is mapped.
  function automatic logic [32:0] view(input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, drive_ctrl_pkg::WORD_ZERO};
    case (a)
      drive_ctrl_pkg::OFF_CTRL:  r[31:0] = 32'(ctrl_q);
      drive_ctrl_pkg::OFF_MODE:  r[31:0] = 32'(mode_q);
      drive_ctrl_pkg::OFF_TRQ:   r[31:0] = trq_q;
      drive_ctrl_pkg::OFF_POS:   r[31:0] = pos_q;
      drive_ctrl_pkg::OFF_CFG:   r[31:0] = 32'(cfg_q);
      drive_ctrl_pkg::OFF_STAT:  r[31:0] = 32'(stat);
      drive_ctrl_pkg::OFF_AMODE: r[31:0] = 32'(act_mode_q);
      drive_ctrl_pkg::OFF_ATORQ: r[31:0] = 32'(atorq_q);
      drive_ctrl_pkg::OFF_APOSL: r[31:0] = 32'(apos_q[15:0]);
      drive_ctrl_pkg::OFF_APOSH: r[31:0] = 32'(apos_hi_q);
      default:                   r = '0;
    endcase
    return r;
  endfunction : view

  // Write channel: address and data are taken in either order, then applied together.
  assign AWREADY_OUT = !aw_hold_q && !BVALID_OUT;
  assign WREADY_OUT  = !w_hold_q && !BVALID_OUT;
  assign do_wr       = aw_hold_q && w_hold_q;
  always_comb {wr_map, wr_old} = view(awaddr_q);
  assign wr_val      = merge(wr_old, wdata_q, wstrb_q);

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      aw_hold_q  <= 1'b0;
      w_hold_q   <= 1'b0;
      awaddr_q   <= '0;
      wdata_q    <= '0;
      wstrb_q    <= '0;
      BVALID_OUT <= 1'b0;
      BRESP_OUT  <= drive_ctrl_pkg::RESP_OKAY;
    end else begin
      if (AWVALID_IN && AWREADY_OUT) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= {AWADDR_IN[7:2], 2'h0};
      end
      if (WVALID_IN && WREADY_OUT) begin
        w_hold_q <= 1'b1;
        wdata_q  <= WDATA_IN;
        wstrb_q  <= WSTRB_IN;
      end
      if (do_wr) begin
        aw_hold_q  <= 1'b0;
        w_hold_q   <= 1'b0;
        BVALID_OUT <= 1'b1;
        BRESP_OUT  <= wr_map ? drive_ctrl_pkg::RESP_OKAY : drive_ctrl_pkg::RESP_SLVERR;
      end else if (BVALID_OUT && BREADY_IN) begin
        BVALID_OUT <= 1'b0;
      end
    end
  end

  // Software-written registers; writes to read-only words are ignored.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ctrl_q <= drive_ctrl_pkg::CTRL_RST;
      mode_q <= drive_ctrl_pkg::MODE_RST;
      trq_q  <= '0;
      pos_q  <= '0;
      cfg_q  <= drive_ctrl_pkg::CFG_RST;
    end else if (do_wr) begin
      case (awaddr_q)
        drive_ctrl_pkg::OFF_CTRL: ctrl_q <= wr_val[$bits(drive_ctrl_pkg::ctrl_t)-1:0];
        drive_ctrl_pkg::OFF_MODE: mode_q <= wr_val[15:0];
        drive_ctrl_pkg::OFF_TRQ:  trq_q  <= wr_val;
        drive_ctrl_pkg::OFF_POS:  pos_q  <= wr_val;
        drive_ctrl_pkg::OFF_CFG:  cfg_q  <= wr_val[$bits(drive_ctrl_pkg::cfg_t)-1:0];
        default: ;
      endcase
    end
  end

  // Read channel; a read of the low position word freezes the high word for a coherent pair.
  assign ARREADY_OUT = !RVALID_OUT;
  assign rd_take     = ARVALID_IN && ARREADY_OUT;
  always_comb {rd_map, rd_word} = view({ARADDR_IN[7:2], 2'h0});

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RVALID_OUT <= 1'b0;
      RDATA_OUT  <= '0;
      RRESP_OUT  <= drive_ctrl_pkg::RESP_OKAY;
      apos_hi_q  <= '0;
    end else begin
      if (rd_take) begin
        RVALID_OUT <= 1'b1;
        RDATA_OUT  <= rd_word;
        RRESP_OUT  <= rd_map ? drive_ctrl_pkg::RESP_OKAY : drive_ctrl_pkg::RESP_SLVERR;
        if ({ARADDR_IN[7:2], 2'h0} == drive_ctrl_pkg::OFF_APOSL) begin
          apos_hi_q <= apos_q[31:16];
        end
      end else if (RVALID_OUT && RREADY_IN) begin
        RVALID_OUT <= 1'b0;
      end
    end
  end

  // Sensor pins pass three flip-flops; a level counts once the last two agree.
  assign mi_vec = {cfg_q.mi2, cfg_q.mi1, cfg_q.mi0};
  for (genvar g = 0; g <= drive_ctrl_pkg::MI_PINS; g++) begin : g_pin
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic f_q;
    logic raw;
    assign raw    = (g == drive_ctrl_pkg::MI_PINS) ? ZPHASE_IN : MI_PIN_IN[g % drive_ctrl_pkg::MI_PINS];
    assign flt[g] = f_q;
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        f_q  <= 1'b0;
      end else begin
        s1_q <= raw;
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          f_q <= s3_q;
        end
      end
    end
    if (g < drive_ctrl_pkg::MI_PINS) begin : g_map
      logic [7:0] code;
      assign code       = mi_vec[g*drive_ctrl_pkg::MI_W +: drive_ctrl_pkg::MI_W];
      assign hit_rev[g] = f_q && (code == drive_ctrl_pkg::MI_REV_LIM);
      assign hit_fwd[g] = f_q && (code == drive_ctrl_pkg::MI_FWD_LIM);
      assign hit_org[g] = f_q && (code == drive_ctrl_pkg::MI_ORIGIN);
    end
  end
  assign rev_lim = |hit_rev;
  assign fwd_lim = |hit_fwd;
  assign org_hit = |hit_org;
  assign z_edge  = flt[drive_ctrl_pkg::MI_PINS] && !z_prev_q;

  // Feedback capture and actual mode report.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      act_mode_q <= drive_ctrl_pkg::MODE_RST;
      atorq_q    <= '0;
      apos_q     <= '0;
      z_prev_q   <= 1'b0;
    end else begin
      if (mode_q <= drive_ctrl_pkg::MODE_HOME) begin
        act_mode_q <= mode_q;
      end
      atorq_q  <= MOTOR_TORQUE_IN;
      apos_q   <= ENC_POS_IN;
      z_prev_q <= flt[drive_ctrl_pkg::MI_PINS];
    end
  end

  // Move trigger must stay high for the minimum time before a move starts.
  assign move_ok = ctrl_q.move && ctrl_q.servo && (mode_q == drive_ctrl_pkg::MODE_POS);
  assign accept  = move_ok && (hold_q == MW'(MOVE_MIN - 1));

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      hold_q      <= '0;
      moving_q    <= 1'b0;
      tgt_q       <= 1'b0;
      MOVE_GO_OUT <= 1'b0;
      POS_CMD_OUT <= '0;
    end else begin
      MOVE_GO_OUT <= accept;
      if (!move_ok) begin
        hold_q <= '0;
      end else if (hold_q != MW'(MOVE_MIN)) begin
        hold_q <= hold_q + MW'(1);
      end
      if (accept) begin
        POS_CMD_OUT <= (ctrl_q.absrel || cfg_q.abs_cfg) ? pos_q : pos_q + ENC_POS_IN;
        moving_q    <= 1'b1;
        tgt_q       <= 1'b0;
      end else if (moving_q && (ENC_POS_IN == POS_CMD_OUT)) begin
        moving_q <= 1'b0;
        tgt_q    <= 1'b1;
      end
    end
  end

  // Origin search: proximity sensor first, then the encoder index marks the origin.
  assign home_go = ctrl_q.home && !home_prev_q && ctrl_q.servo && (mode_q == drive_ctrl_pkg::MODE_HOME);

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      home_st_q   <= drive_ctrl_pkg::H_IDLE;
      home_prev_q <= 1'b0;
    end else begin
      home_prev_q <= ctrl_q.home;
      if (home_go) begin
        home_st_q <= drive_ctrl_pkg::H_SEARCH;
      end else begin
        case (home_st_q)
          drive_ctrl_pkg::H_SEARCH, drive_ctrl_pkg::H_ZWAIT: begin
            if (!ctrl_q.servo || cfg_q.no_z || (rev_lim && fwd_lim)) begin
              home_st_q <= drive_ctrl_pkg::H_FAULT;
            end else if (home_st_q == drive_ctrl_pkg::H_SEARCH && org_hit) begin
              home_st_q <= drive_ctrl_pkg::H_ZWAIT;
            end else if (home_st_q == drive_ctrl_pkg::H_ZWAIT && z_edge) begin
              home_st_q <= drive_ctrl_pkg::H_DONE;
            end
          end
          drive_ctrl_pkg::H_IDLE, drive_ctrl_pkg::H_DONE, drive_ctrl_pkg::H_FAULT: ;
          default: home_st_q <= drive_ctrl_pkg::H_IDLE;
        endcase
      end
    end
  end

  // Drive commands with the control priority applied.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      EXCITE_OUT    <= 1'b0;
      QSTOP_OUT     <= 1'b0;
      HALT_OUT      <= 1'b0;
      FLOCK_OUT     <= 1'b0;
      TRQ_EN_OUT    <= 1'b0;
      TRQ_CMD_OUT   <= '0;
      SPD_LIM_OUT   <= '0;
      HOME_RUN_OUT  <= 1'b0;
      ZERO_HOLD_OUT <= 1'b0;
      STANDBY_OUT   <= 1'b0;
      SBY_OPT_OUT   <= '0;
      treach_q      <= 1'b0;
    end else begin
      EXCITE_OUT    <= ctrl_q.servo;
      QSTOP_OUT     <= ctrl_q.servo && ctrl_q.qstop;
      HALT_OUT      <= ctrl_q.servo && !ctrl_q.qstop && ctrl_q.halt;
      FLOCK_OUT     <= ctrl_q.servo && !ctrl_q.qstop && !ctrl_q.halt && ctrl_q.lock;
      TRQ_EN_OUT    <= ctrl_q.servo && (act_mode_q == drive_ctrl_pkg::MODE_TRQ);
      TRQ_CMD_OUT   <= trq_q[15:0];
      SPD_LIM_OUT   <= trq_q[31:16];
      HOME_RUN_OUT  <= stat.hbusy;
      ZERO_HOLD_OUT <= ctrl_q.servo && !stat.hbusy && cfg_q.foc
                       && (act_mode_q == drive_ctrl_pkg::MODE_HOME);
      STANDBY_OUT   <= ctrl_q.servo && !stat.hbusy && !cfg_q.foc
                       && (act_mode_q == drive_ctrl_pkg::MODE_HOME);
      SBY_OPT_OUT   <= cfg_q.sby_opt;
      treach_q      <= TRQ_EN_OUT && (atorq_q == TRQ_CMD_OUT);
    end
  end

  assign stat.ready  = EXCITE_OUT;
  assign stat.treach = treach_q;
  assign stat.tgt    = tgt_q;
  assign stat.hdone  = (home_st_q == drive_ctrl_pkg::H_DONE);
  assign stat.hfault = (home_st_q == drive_ctrl_pkg::H_FAULT);
  assign stat.sby    = STANDBY_OUT;
  assign stat.zhold  = ZERO_HOLD_OUT;
  assign stat.hbusy  = (home_st_q == drive_ctrl_pkg::H_SEARCH) || (home_st_q == drive_ctrl_pkg::H_ZWAIT);

  chk_mode_report: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    mode_q <= drive_ctrl_pkg::MODE_HOME |=> act_mode_q == $past(mode_q))
    else $error("actual mode does not follow selection");
  chk_torque_apply: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    ctrl_q.servo && act_mode_q == drive_ctrl_pkg::MODE_TRQ |=> TRQ_EN_OUT && TRQ_CMD_OUT == $past(trq_q[15:0]))
    else $error("torque target not applied");
  chk_torque_flag: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    treach_q |-> $past(TRQ_EN_OUT) && $past(atorq_q) == $past(TRQ_CMD_OUT))
    else $error("torque attained without match");
  chk_move_gate: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    MOVE_GO_OUT |-> $past(mode_q == drive_ctrl_pkg::MODE_POS && ctrl_q.servo && ctrl_q.move)
                    && !$past(MOVE_GO_OUT))
    else $error("move started outside position mode");
  chk_abs_target: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    MOVE_GO_OUT |-> POS_CMD_OUT == ($past(ctrl_q.absrel || cfg_q.abs_cfg) ? $past(pos_q)
                                    : $past(pos_q) + $past(ENC_POS_IN)))
    else $error("move target wrongly referenced");
  chk_home_gate: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    home_st_q == drive_ctrl_pkg::H_SEARCH && $past(home_st_q) != drive_ctrl_pkg::H_SEARCH
    |-> $past(mode_q == drive_ctrl_pkg::MODE_HOME && ctrl_q.servo && ctrl_q.home))
    else $error("origin search started without homing mode");
  chk_home_index: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    $rose(stat.hdone) |-> $past(z_edge) && !$past(cfg_q.no_z))
    else $error("homing done without index");
  chk_servo_keep: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    $fell(ctrl_q.servo) |-> $past(do_wr && awaddr_q == drive_ctrl_pkg::OFF_CTRL))
    else $error("servo dropped without a write");
  chk_ctrl_order: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    QSTOP_OUT || HALT_OUT || FLOCK_OUT |-> EXCITE_OUT && $onehot({QSTOP_OUT, HALT_OUT, FLOCK_OUT}))
    else $error("control priority violated");
  chk_target_flag: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    $rose(tgt_q) |-> $past(ENC_POS_IN) == POS_CMD_OUT ##0 !MOVE_GO_OUT)
    else $error("target reached flag wrong");
  chk_standby_sel: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    STANDBY_OUT || ZERO_HOLD_OUT |-> !(STANDBY_OUT && ZERO_HOLD_OUT) && STANDBY_OUT == !$past(cfg_q.foc))
    else $error("standby and zero hold mixed");
  chk_bus_hold: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
    else $error("write response dropped");
endmodule : drive_mode_ctrl
`default_nettype wire

// >>> tb/motor_model.sv
// Motor with encoder and homing sensors facing the mode controller.
// Assumes the controller's outputs and this model share one clock.
`timescale 1ns/10ps
`default_nettype none
module motor_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        trq_en_in,
  input  wire logic [15:0] trq_cmd_in,
  input  wire logic [31:0] pos_cmd_in,
  input  wire logic        home_run_in,
  output logic      [15:0] torque_out,
  output logic      [31:0] enc_pos_out,
  output logic      [2:0]  mi_pin_out,
  output logic             zphase_out
);
  logic [3:0] ph_q;
  // The shaft steps one count a cycle toward the commanded position.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      torque_out  <= 16'h0000;
      enc_pos_out <= 32'h0000_0000;
      ph_q        <= 4'h0;
      mi_pin_out  <= 3'h0;
      zphase_out  <= 1'b0;
    end else begin
      torque_out <= trq_en_in ? trq_cmd_in : 16'h0000;
      if (enc_pos_out != pos_cmd_in) begin
        enc_pos_out <= ($signed(enc_pos_out) < $signed(pos_cmd_in)) ? enc_pos_out + 1 : enc_pos_out - 1;
      end
      ph_q       <= home_run_in ? ph_q + 4'h1 : 4'h0;
      mi_pin_out <= {home_run_in && (|ph_q[3:2]), 2'b00};
      zphase_out <= home_run_in && (&ph_q[3:1]);
    end
  end
endmodule : motor_model
`default_nettype wire

// >>> tb/tb_drive_mode_ctrl.sv
// Testbench of the drive mode controller: register-bus tasks and mode scenarios.
// Assumes the motor model closes the torque and position loops.
`timescale 1ns/10ps
`default_nettype none
module tb_drive_mode_ctrl;
  localparam int MM = 4;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, v, rdata, pos_cmd, enc;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, t_en, run, exc, sby, z, qs, hl, fl, zh, mg;
  logic [1:0]  bresp, rresp, so;
  logic [15:0] tq, tq_cmd, lim;
  logic [2:0]  mi;
  int          bad_count = 0, samples_checked = 0, go_n = 0;
  always #25 clk = ~clk;
  // Counts move-start pulses; each stands for one cycle and so spans one falling edge.
  always @(negedge clk) if (mg) go_n++;
  drive_mode_ctrl #(.MOVE_MIN(MM)) u_drive_mode_ctrl (.CLK_IN(clk), .RST_N_IN(rst_n),
    .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(aw_rdy), .WDATA_IN(wdata), .WSTRB_IN(4'hf),
    .WVALID_IN(wvalid), .WREADY_OUT(w_rdy), .BRESP_OUT(bresp), .BVALID_OUT(b_vld), .BREADY_IN(bready),
    .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(ar_rdy), .RDATA_OUT(rdata), .RRESP_OUT(rresp),
    .RVALID_OUT(r_vld), .RREADY_IN(rready), .MOTOR_TORQUE_IN(tq), .ENC_POS_IN(enc), .MI_PIN_IN(mi),
    .ZPHASE_IN(z), .EXCITE_OUT(exc), .QSTOP_OUT(qs), .HALT_OUT(hl), .FLOCK_OUT(fl), .TRQ_EN_OUT(t_en),
    .TRQ_CMD_OUT(tq_cmd), .SPD_LIM_OUT(lim), .POS_CMD_OUT(pos_cmd), .MOVE_GO_OUT(mg), .HOME_RUN_OUT(run),
    .ZERO_HOLD_OUT(zh), .STANDBY_OUT(sby), .SBY_OPT_OUT(so));
  motor_model u_motor_model (.clk_in(clk), .rst_n_in(rst_n), .trq_en_in(t_en), .trq_cmd_in(tq_cmd),
    .pos_cmd_in(pos_cmd), .home_run_in(run), .torque_out(tq), .enc_pos_out(enc), .mi_pin_out(mi),
    .zphase_out(z));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  // Readies are sampled on the falling edge, where they equal their value at the next rising edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    logic [1:0] r;
    int n;
    tb = 1'b0;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb && n < 50) begin
      @(negedge clk);
      ta = awvalid && aw_rdy;
      tw = wvalid && w_rdy;
      tb = b_vld;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    chk("bresp", 32'h0, {30'h0, r});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ta, tr;
    logic [1:0] r;
    int n;
    tr = 1'b0;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr && n < 50) begin
      @(negedge clk);
      ta = arvalid && ar_rdy;
      tr = r_vld;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask : rd
  task automatic wt(input int b);
    int n;
    n = 0;
    v = 32'h0;
    while (v[b] !== 1'b1 && n < 300) begin
      rd(drive_ctrl_pkg::OFF_STAT, 2'h0, v);
      n++;
    end
    chk("stat bit", 32'h1, {31'h0, v[b]});
  endtask : wt
  task automatic mv(input logic [31:0] p, input logic ab, input logic [31:0] e);
    wr(drive_ctrl_pkg::OFF_POS, p);
    wr(drive_ctrl_pkg::OFF_CTRL, {29'h0, ab, 2'b11});
    repeat (MM + 2) @(posedge clk);
    wr(drive_ctrl_pkg::OFF_CTRL, {29'h0, ab, 2'b01});
    chk("pos_cmd", e, pos_cmd);
    wt(2);
  endtask : mv
  initial begin
    #3000000;
    bad_count++;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(drive_ctrl_pkg::OFF_CFG, 2'h0, v);
    chk("cfg", 32'h05c5_a580, v);
    rd(drive_ctrl_pkg::OFF_AMODE, 2'h0, v);
    chk("amode", 32'h0, v);
    rd(8'h40, drive_ctrl_pkg::RESP_SLVERR, v);
    chk("unmapped", 32'h0, v);
    $display("test reset done");
    wr(drive_ctrl_pkg::OFF_CFG, 32'h05c5_a580);
    wr(drive_ctrl_pkg::OFF_MODE, 32'h2);
    wr(drive_ctrl_pkg::OFF_TRQ, 32'h03e8_ff38);
    wr(drive_ctrl_pkg::OFF_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    chk("torque_target_command_cmd", 32'hff38, {16'h0, tq_cmd});
    chk("spd_lim", 32'h03e8, {16'h0, lim});
    chk("torque_target_command_en", 32'h1, {31'h0, t_en});
    rd(drive_ctrl_pkg::OFF_AMODE, 2'h0, v);
    chk("amode", 32'h2, v);
    wt(1);
    rd(drive_ctrl_pkg::OFF_ATORQ, 2'h0, v);
    chk("atorq", 32'hff38, {16'h0, v[15:0]});
    wr(drive_ctrl_pkg::OFF_CTRL, 32'h71);
    repeat (3) @(posedge clk);
    chk("qstop", 32'hc, {28'h0, exc, qs, hl, fl});
    wr(drive_ctrl_pkg::OFF_CTRL, 32'h61);
    repeat (3) @(posedge clk);
    chk("halt", 32'ha, {28'h0, exc, qs, hl, fl});
    wr(drive_ctrl_pkg::OFF_CTRL, 32'h41);
    repeat (3) @(posedge clk);
    chk("flock", 32'h9, {28'h0, exc, qs, hl, fl});
    wr(drive_ctrl_pkg::OFF_CTRL, 32'h70);
    repeat (3) @(posedge clk);
    chk("servo off", 32'h0, {28'h0, exc, qs, hl, fl});
    wr(drive_ctrl_pkg::OFF_CTRL, 32'h3);
    repeat (MM + 2) @(posedge clk);
    wr(drive_ctrl_pkg::OFF_CTRL, 32'h1);
    chk("pos_cmd", 32'h0, pos_cmd);
    $display("test torque done");
    wr(drive_ctrl_pkg::OFF_MODE, 32'h1);
    wr(drive_ctrl_pkg::OFF_CTRL, 32'h9);
    repeat (3) @(posedge clk);
    chk("home_run", 32'h0, {31'h0, run});
    wr(drive_ctrl_pkg::OFF_CTRL, 32'h1);
    wr(drive_ctrl_pkg::OFF_MODE, 32'h3);
    repeat (3) @(posedge clk);
    chk("standby", 32'h1, {31'h0, sby});
    wr(drive_ctrl_pkg::OFF_CTRL, 32'h9);
    repeat (3) @(posedge clk);
    chk("home_run", 32'h1, {31'h0, run});
    wt(3);
    chk("hfault", 32'h0, {31'h0, v[4]});
    wr(drive_ctrl_pkg::OFF_MODE, 32'h1);
    rd(drive_ctrl_pkg::OFF_AMODE, 2'h0, v);
    chk("amode", 32'h1, v);
    chk("excite", 32'h1, {31'h0, exc});
    $display("test homing done");
    mv(32'd100, 1'b1, 32'd100);
    mv(-32'sd20, 1'b0, 32'd80);
    mv(-32'sd5, 1'b1, 32'hffff_fffb);
    rd(drive_ctrl_pkg::OFF_APOSL, 2'h0, v);
    chk("apos low", 32'hfffb, {16'h0, v[15:0]});
    rd(drive_ctrl_pkg::OFF_APOSH, 2'h0, v);
    chk("apos high", 32'hffff, {16'h0, v[15:0]});
    $display("test position done");
    wr(drive_ctrl_pkg::OFF_CFG, 32'h05c5_a593);
    wr(drive_ctrl_pkg::OFF_MODE, 32'h3);
    repeat (3) @(posedge clk);
    chk("zero_hold", 32'h2, {30'h0, zh, sby});
    chk("sby_opt", 32'h2, {30'h0, so});
    wr(drive_ctrl_pkg::OFF_CTRL, 32'h9);
    wt(4);
    chk("hdone", 32'h0, {31'h0, v[3]});
    chk("moves", 32'h3, go_n);
    $display("test fault done");
    print_verdict;
  end
endmodule : tb_drive_mode_ctrl
`default_nettype wire
